/* File: rrc_pkg.sv */
/*
 Register slice constants: offsets, field positions, reset values, encodings.
 Assumes an 8-bit register port inside the device; no other bus.
*/
`default_nettype none
package rrc_pkg;
	localparam logic [7:0] OFF_PERIOD_UPPER = 8'h05;
	localparam logic [7:0] OFF_PERIOD_LOWER = 8'h06;
	localparam logic [7:0] OFF_CONFIG       = 8'h07;
	localparam int PERIOD_W = 10;
	localparam int AVG_DEPTH = 4;
	localparam logic [6:0] GROUP_ADDR       = 7'h58;
	// Period step in nanoseconds per count
	localparam int PERIOD_STEP_NS = 24390;
	localparam int CFG_GROUP_BIT   = 7;
	localparam int CFG_AVGDIS_BIT  = 6;
	localparam int CFG_COMP_LSB    = 4;
	localparam int CFG_PIN_LSB     = 2;
	localparam int CFG_MODE_LSB    = 0;
	localparam logic [7:0] CONFIG_RESET = 8'h54;
	localparam logic [5:0] UPPER_RSV_RESET = 6'h00;
	localparam logic [4:0] IRQ_MASK_RESET = 5'h18;
	typedef enum logic [1:0] {
		PIN_PULSE_TRIG = 2'b00,
		PIN_LEVEL_TRIG = 2'b01,
		PIN_IRQ_OUT    = 2'b10,
		PIN_RESERVED   = 2'b11
	} rrc_pin_t;
	typedef enum logic [1:0] {
		MODE_REALTIME  = 2'b00,
		MODE_SEQUENCER = 2'b01,
		MODE_DIAG      = 2'b10,
		MODE_CALIB     = 2'b11
	} rrc_mode_t;
	// Compensation in tenths of a percent, per select code
	localparam logic [5:0] COMP_CODE0 = 6'h00;
	localparam logic [5:0] COMP_CODE1 = 6'h14;
	localparam logic [5:0] COMP_CODE2 = 6'h28;
	localparam logic [5:0] COMP_CODE3 = 6'h32;
endpackage
`default_nettype wire

/* File: rrc_regs.sv */
/*
 Resonance period report and configuration registers of a haptic driver.
 Assumes a register port from the serial host logic on the same clock,
 and playback engine indications on the same clock. Trigger pin is async.
*/
`timescale 1ns/1ps
`default_nettype none
module rrc_regs
	import rrc_pkg::*;
#(
	parameter int PW = 10
) (
	// Clock and reset
	input  wire logic                 CLK_IN,
	input  wire logic                 RST_IN,
	// Register port
	input  wire logic [7:0]           ADDR_IN,
	input  wire logic                 WR_IN,
	input  wire logic                 RD_IN,
	input  wire logic [7:0]           WDATA_IN,
	output logic      [7:0]           RDATA_OUT,
	// Target address match
	input  wire logic [6:0]           BUS_ADDR_IN,
	input  wire logic [6:0]           OWN_ADDR_IN,
	output logic                      ADDR_MATCH_OUT,
	// Playback engine
	input  wire logic                 PLAY_ACTIVE_IN,
	input  wire logic                 WAVE_DONE_IN,
	input  wire logic                 BRAKING_IN,
	input  wire logic                 PROC_RUN_IN,
	input  wire logic                 PERIOD_VALID_IN,
	input  wire logic [PW-1:0]        PERIOD_MEAS_IN,
	input  wire logic                 GO_WRITE_IN,
	output logic                      START_OUT,
	output logic                      CANCEL_OUT,
	output logic                      ABORT_STANDBY_OUT,
	output logic      [1:0]           MODE_OUT,
	output logic      [5:0]           COMP_FACTOR_OUT,
	// Interrupt sources and mask
	input  wire logic [4:0]           STATUS_IN,
	input  wire logic [4:0]           IRQ_MASK_IN,
	// Trigger or interrupt pin
	input  wire logic                 TRIG_PIN_IN,
	output logic                      TRIG_PIN_OUT,
	output logic                      TRIG_PIN_OE_OUT
);
	// Configuration byte and abort request
	logic [7:0]    config_r;
	logic [7:0]    next_config;
	logic [5:0]    upper_rsv;
	logic [5:0]    next_upper_rsv;
	logic          abort;
	logic          next_abort;
	logic          cfg_write;
	logic          upper_write;
	logic          pin_changed;
	logic          mode_changed;

	// Read data and freeze lock
	logic [7:0]    rdata;
	logic [7:0]    next_rdata;
	logic          frozen;
	logic          next_frozen;

	// Period history and report
	logic [PW-1:0] hist [AVG_DEPTH];
	logic [PW-1:0] next_hist [AVG_DEPTH];
	logic [PW-1:0] period;
	logic [PW-1:0] next_period;
	logic [PW+1:0] sum;
	logic          sample_take;
	logic          report_update;

	// Trigger pin synchroniser and process requests
	logic [2:0]    pin_sync;
	logic [2:0]    next_pin_sync;
	logic          pin_level;
	logic          next_pin_level;
	logic          pin_edge;
	logic          go_allowed;
	logic          start;
	logic          next_start;
	logic          cancel;
	logic          next_cancel;

	// Interrupt pin drive
	logic          irq_drive;
	logic          next_irq_drive;
	logic [4:0]    irq_pending;
	rrc_pin_t      pin_fn;

	assign pin_fn = rrc_pin_t'(config_r[CFG_PIN_LSB +: 2]);

	// Configuration group
	always_comb begin
		cfg_write      = WR_IN && (ADDR_IN == OFF_CONFIG);
		upper_write    = WR_IN && (ADDR_IN == OFF_PERIOD_UPPER);
		pin_changed    = WDATA_IN[CFG_PIN_LSB +: 2] != config_r[CFG_PIN_LSB +: 2];
		mode_changed   = WDATA_IN[CFG_MODE_LSB +: 2] != config_r[CFG_MODE_LSB +: 2];
		next_config    = config_r;
		next_upper_rsv = upper_rsv;
		next_abort     = 1'b0;
		if (cfg_write) begin
			next_config = WDATA_IN;
			if (PROC_RUN_IN && pin_changed) begin
				next_abort = 1'b1;
			end
			if (PROC_RUN_IN && mode_changed) begin
				next_abort = 1'b1;
			end
		end
		// Period bits are read-only; only the spare upper bits store
		if (upper_write) begin
			next_upper_rsv = WDATA_IN[7:2];
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			config_r  <= CONFIG_RESET;
			upper_rsv <= UPPER_RSV_RESET;
			abort     <= 1'b0;
		end else begin
			config_r  <= next_config;
			upper_rsv <= next_upper_rsv;
			abort     <= next_abort;
		end
	end

	// Read group; finishing waveform releases a pending lock
	always_comb begin
		next_rdata  = rdata;
		next_frozen = frozen;
		if (RD_IN) begin
			unique case (ADDR_IN)
				OFF_PERIOD_UPPER: begin
					next_rdata  = {upper_rsv, period[PW-1:8]};
					next_frozen = 1'b1;
				end
				OFF_PERIOD_LOWER: begin
					next_rdata  = period[7:0];
					next_frozen = 1'b0;
				end
				OFF_CONFIG: begin
					next_rdata = config_r;
				end
				default: begin
					next_rdata = 8'h00;
				end
			endcase
		end
		if (WAVE_DONE_IN) begin
			next_frozen = 1'b0;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			rdata  <= 8'h00;
			frozen <= 1'b0;
		end else begin
			rdata  <= next_rdata;
			frozen <= next_frozen;
		end
	end

	// Period group; braking samples pass through unchecked
	always_comb begin
		sample_take   = PERIOD_VALID_IN && PLAY_ACTIVE_IN;
		report_update = !frozen && PLAY_ACTIVE_IN;
		sum           = {2'b00, hist[0]} + {2'b00, hist[1]} + {2'b00, hist[2]} + {2'b00, hist[3]};
		next_hist     = hist;
		next_period   = period;
		if (sample_take) begin
			next_hist[0] = PERIOD_MEAS_IN;
			for (int i = 1; i < AVG_DEPTH; i++) begin
				next_hist[i] = hist[i-1];
			end
		end
		if (report_update) begin
			if (config_r[CFG_AVGDIS_BIT]) begin
				next_period = hist[0];
			end else begin
				next_period = sum[PW+1:2];
			end
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			period <= '0;
			for (int i = 0; i < AVG_DEPTH; i++) begin
				hist[i] <= '0;
			end
		end else begin
			period <= next_period;
			hist   <= next_hist;
		end
	end

	// Trigger group; a pin change counts once stages two and three agree
	always_comb begin
		next_pin_sync  = {pin_sync[1:0], TRIG_PIN_IN};
		pin_edge       = (pin_sync[1] == pin_sync[2]) && (pin_sync[2] != pin_level);
		go_allowed     = (pin_fn == PIN_PULSE_TRIG) || (pin_fn == PIN_IRQ_OUT);
		next_pin_level = pin_level;
		next_start     = 1'b0;
		next_cancel    = 1'b0;
		if (pin_edge) begin
			next_pin_level = pin_sync[2];
			if ((pin_fn == PIN_PULSE_TRIG) && pin_sync[2]) begin
				next_start  = !PROC_RUN_IN;
				next_cancel = PROC_RUN_IN;
			end
		end
		if (pin_fn == PIN_LEVEL_TRIG) begin
			next_start  = pin_level && !PROC_RUN_IN;
			next_cancel = !pin_level && PROC_RUN_IN;
		end
		if (GO_WRITE_IN && go_allowed) begin
			next_start  = !PROC_RUN_IN;
			next_cancel = PROC_RUN_IN;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			pin_sync  <= 3'b000;
			pin_level <= 1'b0;
			start     <= 1'b0;
			cancel    <= 1'b0;
		end else begin
			pin_sync  <= next_pin_sync;
			pin_level <= next_pin_level;
			start     <= next_start;
			cancel    <= next_cancel;
		end
	end

	// Interrupt group; with the pin set to PIN_IRQ_OUT, open drain pulls low while an unmasked flag is set
	always_comb begin
		irq_pending    = STATUS_IN & ~IRQ_MASK_IN;
		next_irq_drive = (pin_fn == PIN_IRQ_OUT) && (|irq_pending);
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			irq_drive <= 1'b0;
		end else begin
			irq_drive <= next_irq_drive;
		end
	end

	assign RDATA_OUT         = rdata;
	assign START_OUT         = start;
	assign CANCEL_OUT        = cancel;
	assign ABORT_STANDBY_OUT = abort;
	assign MODE_OUT          = config_r[CFG_MODE_LSB +: 2];
	assign TRIG_PIN_OUT      = 1'b0;
	assign TRIG_PIN_OE_OUT   = irq_drive;
	assign ADDR_MATCH_OUT    = (BUS_ADDR_IN == OWN_ADDR_IN) ||
		(config_r[CFG_GROUP_BIT] && BUS_ADDR_IN == GROUP_ADDR);

	always_comb begin
		unique case (config_r[CFG_COMP_LSB +: 2])
			2'b00: COMP_FACTOR_OUT = COMP_CODE0;
			2'b01: COMP_FACTOR_OUT = COMP_CODE1;
			2'b10: COMP_FACTOR_OUT = COMP_CODE2;
			2'b11: COMP_FACTOR_OUT = COMP_CODE3;
		endcase
	end
	// Period in time is value times PERIOD_STEP_NS; reported as raw count
endmodule
`default_nettype wire

/* File: rrc_regs_checker.sv */
/* Port checker for rrc_regs.
 Assumes one clock and a synchronous active-high reset; bound to every rrc_regs. */
`timescale 1ns/1ps
`default_nettype none
module rrc_regs_checker
	import rrc_pkg::*;
(
	input wire logic       CLK_IN, RST_IN, WR_IN, RD_IN, PROC_RUN_IN, ADDR_MATCH_OUT,
	input wire logic       ABORT_STANDBY_OUT, TRIG_PIN_OE_OUT,
	input wire logic [7:0] ADDR_IN, WDATA_IN, RDATA_OUT,
	input wire logic [6:0] BUS_ADDR_IN, OWN_ADDR_IN,
	input wire logic [4:0] STATUS_IN, IRQ_MASK_IN,
	input wire logic [5:0] COMP_FACTOR_OUT,
	input wire logic [1:0] MODE_OUT
);
	localparam logic [23:0] LUT = {6'h32, 6'h28, 6'h14, 6'h00};
	wire logic       cfg_wr = WR_IN && ADDR_IN == OFF_CONFIG;
	wire logic [1:0] w_mode = WDATA_IN[1:0];
	wire logic [1:0] w_comp = WDATA_IN[5:4];
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);
	a_read_hold: assert property (!RD_IN |=> $stable(RDATA_OUT)) else $error("rdata moved");
	a_unmapped_zero: assert property (RD_IN && ADDR_IN > OFF_CONFIG |=> RDATA_OUT == 8'h00)
		else $error("unmapped read not zero");
	a_mode_follow: assert property (cfg_wr |=> MODE_OUT == $past(w_mode))
		else $error("mode not taken");
	a_comp_table: assert property (cfg_wr |=> COMP_FACTOR_OUT == LUT[$past(w_comp)*6 +: 6])
		else $error("compensation wrong");
	a_abort_cause: assert property (ABORT_STANDBY_OUT |-> $past(cfg_wr) && $past(PROC_RUN_IN))
		else $error("abort without cause");
	a_abort_change: assert property (cfg_wr && PROC_RUN_IN && w_mode != MODE_OUT |=> ABORT_STANDBY_OUT)
		else $error("mode change kept running");
	a_own_match: assert property (BUS_ADDR_IN == OWN_ADDR_IN |-> ADDR_MATCH_OUT)
		else $error("own address missed");
	a_irq_masked: assert property ((STATUS_IN & ~IRQ_MASK_IN) == 5'h00 |=> !TRIG_PIN_OE_OUT)
		else $error("masked flag drove pin");
	c_freeze: cover property (RD_IN && ADDR_IN == OFF_PERIOD_UPPER);
	c_abort: cover property (ABORT_STANDBY_OUT);
	c_irq: cover property (TRIG_PIN_OE_OUT);
endmodule
bind rrc_regs rrc_regs_checker i_rrc_regs_checker (.*);
`default_nettype wire

/* File: rrc_host.sv */
/* Host model on the register port of rrc_regs.
 Assumes the bench clock; drives on the falling edge, holds over the taking edge. */
`timescale 1ns/1ps
`default_nettype none
module rrc_host
	import rrc_pkg::*;
(
	input wire logic       CLK_IN,
	input wire logic [7:0] RDATA_IN,
	output var logic [7:0] ADDR_OUT, WDATA_OUT,
	output var logic       WR_OUT, RD_OUT
);
	initial {ADDR_OUT, WDATA_OUT, WR_OUT, RD_OUT} = 18'h00000;
	task automatic wr(input logic [7:0] a, d);
		@(negedge CLK_IN) {ADDR_OUT, WDATA_OUT, WR_OUT} = {a, d, 1'b1};
		@(negedge CLK_IN) {WDATA_OUT, WR_OUT} = {~d, 1'b0};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge CLK_IN) {ADDR_OUT, RD_OUT} = {a, 1'b1};
		@(negedge CLK_IN) RD_OUT = 1'b0;
		d = RDATA_IN;
	endtask
	// Upper half first to freeze the report; a report update on the edge that takes the upper read still reaches the lower half
	task automatic rd_period(output logic [9:0] p);
		logic [7:0] u, l;
		rd(OFF_PERIOD_UPPER, u);
		rd(OFF_PERIOD_LOWER, l);
		p = {u[1:0], l};
	endtask
endmodule
`default_nettype wire

/* File: rrc_regs_tb.sv */
/* Self-checking bench for rrc_regs.
 Assumes rrc_host drives the register port; the bench plays the engine side. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module rrc_regs_tb import rrc_pkg::*; ;
	logic        clk, rst, wr, rd, play, done, proc, pval, go, trig, start, match, abort, oe, f;
	logic [7:0]  addr, wdata, rdata, r;
	logic [9:0]  meas, s, p;
	logic [11:0] sum;
	logic [4:0]  stat, mask;
	logic [5:0]  comp;
	logic [1:0]  mode;
	int          bad_count, comparisons, cyc;
	logic [1:0]  pm[5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
	logic        ep[5] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h1};
	logic [5:0]  ct[4] = '{6'h00, 6'h14, 6'h28, 6'h32};
	logic [6:0]  bus;
	rrc_regs i_rrc_regs (.CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WR_IN(wr), .RD_IN(rd),
		.WDATA_IN(wdata), .RDATA_OUT(rdata), .BUS_ADDR_IN(bus), .OWN_ADDR_IN(7'h2A),
		.ADDR_MATCH_OUT(match), .PLAY_ACTIVE_IN(play), .WAVE_DONE_IN(done), .BRAKING_IN(1'h0),
		.PROC_RUN_IN(proc), .PERIOD_VALID_IN(pval), .PERIOD_MEAS_IN(meas), .GO_WRITE_IN(go),
		.START_OUT(start), .CANCEL_OUT(), .ABORT_STANDBY_OUT(abort), .MODE_OUT(mode),
		.COMP_FACTOR_OUT(comp), .STATUS_IN(stat), .IRQ_MASK_IN(mask), .TRIG_PIN_IN(trig),
		.TRIG_PIN_OUT(), .TRIG_PIN_OE_OUT(oe));
	rrc_host i_rrc_host (.CLK_IN(clk), .RDATA_IN(rdata), .ADDR_OUT(addr), .WDATA_OUT(wdata),
		.WR_OUT(wr), .RD_OUT(rd));
	initial begin clk = 1'h0; forever #50 clk = ~clk; end
	always @(posedge clk) if (++cyc == 4000) begin bad_count++; complete_run(); end
	task automatic feed(input logic [9:0] v);
		@(negedge clk) {meas, pval} = {v, 1'h1};
		@(negedge clk) {meas, pval} = {~v, 1'h0};
	endtask
	task automatic kick(input logic pin, output logic hit);
		hit = 1'h0;
		@(negedge clk) {go, trig} = {~pin, pin};
		repeat (8) @(negedge clk) {go, hit} = {1'h0, hit | start};
		trig = 1'h0;
	endtask
	task automatic complete_run();
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		{play, done, proc, pval, go, trig, meas, stat, mask, sum} = '0;
		{rst, bus, s} = {1'h1, 7'h2A, 10'($urandom(45))};
		repeat (5) @(negedge clk);
		{rst, play} = 2'h1;
		i_rrc_host.wr(OFF_PERIOD_UPPER, 8'hFF);
		i_rrc_host.wr(OFF_PERIOD_LOWER, 8'hFF);
		i_rrc_host.rd(OFF_PERIOD_UPPER, r);
		`CHK("upper", 8'hFC, r)
		i_rrc_host.rd(OFF_PERIOD_LOWER, r);
		`CHK("lower", 8'h00, r)
		i_rrc_host.rd(OFF_CONFIG, r);
		`CHK("config", 8'h54, r)
		i_rrc_host.rd(8'h08, r);
		`CHK("unmapped", 8'h00, r)
		i_rrc_host.wr(OFF_CONFIG, 8'h14);
		for (int i = 0; i < 4; i++) begin
			s = 10'($urandom);
			sum = sum + 12'(s);
			feed(s);
		end
		i_rrc_host.rd_period(p);
		`CHK("average", sum[11:2], p)
		i_rrc_host.rd(OFF_PERIOD_UPPER, r);
		feed(10'h3FF);
		i_rrc_host.rd(OFF_PERIOD_LOWER, r);
		`CHK("frozen", sum[9:2], r)
		i_rrc_host.wr(OFF_CONFIG, 8'h54);
		i_rrc_host.rd(OFF_PERIOD_UPPER, r);
		@(negedge clk) done = 1'h1;
		@(negedge clk) done = 1'h0;
		s = 10'($urandom);
		feed(s);
		i_rrc_host.rd_period(p);
		`CHK("latest", s, p)
		play = 1'h0;
		feed(~s);
		i_rrc_host.rd_period(p);
		`CHK("idle", s, p)
		proc = 1'h1;
		for (int i = 0; i < 4; i++) begin
			i_rrc_host.wr(OFF_CONFIG, {2'h1, 2'(i), 2'h2, 2'(i)});
			`CHK("abort", 1'h1, abort)
			`CHK("mode", 2'(i), mode)
			`CHK("comp", ct[i], comp)
		end
		i_rrc_host.wr(OFF_CONFIG, 8'h7B);
		`CHK("abort", 1'h0, abort)
		proc = 1'h0;
		for (int i = 0; i < 5; i++) begin
			i_rrc_host.wr(OFF_CONFIG, {4'h5, pm[i], 2'h0});
			kick(i == 4, f);
			`CHK("start", ep[i], f)
		end
		i_rrc_host.wr(OFF_CONFIG, 8'h58);
		for (int i = 0; i < 9; i++) begin
			@(negedge clk) {stat, mask} = (i == 8) ? 10'h3E0 : 10'($urandom);
			@(negedge clk) `CHK("irq", |(stat & ~mask), oe)
		end
		bus = GROUP_ADDR;
		for (int i = 0; i < 2; i++) begin
			i_rrc_host.wr(OFF_CONFIG, {i[0], 7'h50});
			`CHK("group", i[0], match)
			@(negedge clk);
			`CHK("irq off", 1'h0, oe)
		end
		complete_run();
	end
endmodule
`default_nettype wire
